// ### hdl/port_blink_pwm_output_control.sv
`timescale 1ns/100ps

// How it works
// - blink flag and flip pick the level register
// - blink off uses phase-zero register only
// - level one releases port, zero pulls low
// - direction register: one input, zero output
// - level registers read back stored contents
// - ninth output set by two control bits
// - oscillator near 32kHz, stopped when PWM off
// - period of fifteen slots of sixteen cycles
// - master value gates one to fifteen slots
// - per-output setting acts inside gated slots
// - setting fifteen gives static level, no PWM
// - phase-zero bit sets level during on-time
// - blink phases each set on-time level
// - ninth field doubles as global setting
// - master and ninth fields form global control
// - global setting covers every output together
// - master zero stops oscillator, outputs static
// - intensity byte holds odd high, even low
// - ninth phase levels from first, second bits
module port_blink_pwm_output_control
    import port_pwm_pkg::*;
#(
    parameter int PORTS = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic      [7:0]       reg_rdata,
    input  wire logic [PORTS-1:0] port_in,
    output logic      [PORTS-1:0] port_out,
    output logic      [PORTS-1:0] port_drive_n,
    output logic                  ninth_output,
    output logic                  ninth_drive_n
);

    logic [7:0]       phase_zero_levels;
    logic [7:0]       phase_one_levels;
    logic [7:0]       port_direction;
    logic [7:0]       master_reg;
    config_type       cfg;
    logic [7:0]       intensity_regs [4];
    logic [10:0]      osc_div;
    logic [3:0]       slot;
    logic [3:0]       cycle;
    logic             osc_tick;
    logic [3:0]       master;
    logic [3:0]       global_setting;
    logic [7:0]       selected_levels;
    logic [PORTS-1:0] next_drive_n;
    logic             ninth_level;
    logic             next_ninth_drive_n;

    localparam logic [10:0] DIV_LAST = 11'(OSC_DIV - 1);

    function automatic logic pin_level(input logic lvl, input logic [3:0] setting,
                                       input logic [3:0] mstr, input logic [3:0] s,
                                       input logic [3:0] c);
        logic on_time;
        on_time = 1'b1;
        if (setting != SETTING_STATIC && mstr != 4'h0) begin
            on_time = (s < mstr) && (c <= setting);
        end
        return on_time ? lvl : ~lvl;
    endfunction : pin_level

    assign master         = master_reg[MASTER_LSB +: NIBBLE];
    assign global_setting = master_reg[NIBBLE-1:0];
    assign osc_tick       = (osc_div == DIV_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Register writes

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_zero_levels <= RESET_LEVELS;
            phase_one_levels  <= RESET_LEVELS;
            port_direction    <= RESET_DIRECTION;
            master_reg        <= RESET_MASTER;
            cfg               <= config_type'(RESET_CONFIG[5:0]);
            for (int i = 0; i < 4; i++) begin
                intensity_regs[i] <= RESET_INTENSITY;
            end
        end else if (reg_write) begin
            unique case (reg_addr)
                ADDR_PHASE_ZERO: phase_zero_levels <= reg_wdata;
                ADDR_PHASE_ONE:  phase_one_levels  <= reg_wdata;
                ADDR_DIRECTION:  port_direction    <= reg_wdata;
                ADDR_MASTER:     master_reg        <= reg_wdata;
                ADDR_CONFIG:     cfg               <= config_type'(reg_wdata[5:0]);
                default: begin
                    if (reg_addr >= ADDR_INTENSITY0 && reg_addr <= ADDR_INTENSITY3) begin
                        intensity_regs[reg_addr[1:0]] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads, one cycle after the read strobe

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= READ_UNMAPPED;
        end else if (reg_read) begin
            unique case (reg_addr)
                ADDR_INPUT_LEVELS: reg_rdata <= port_in;
                ADDR_PHASE_ZERO:   reg_rdata <= phase_zero_levels;
                ADDR_PHASE_ONE:    reg_rdata <= phase_one_levels;
                ADDR_DIRECTION:    reg_rdata <= port_direction;
                ADDR_MASTER:       reg_rdata <= master_reg;
                ADDR_CONFIG:       reg_rdata <= {2'b00, cfg};
                default: begin
                    if (reg_addr >= ADDR_INTENSITY0 && reg_addr <= ADDR_INTENSITY3) begin
                        reg_rdata <= intensity_regs[reg_addr[1:0]];
                    end else begin
                        reg_rdata <= READ_UNMAPPED;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PWM oscillator and counters, held at zero while master is zero

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_div <= '0;
        end else if (master == 4'h0 || osc_tick) begin
            osc_div <= '0;
        end else begin
            osc_div <= osc_div + 11'd1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slot  <= '0;
            cycle <= '0;
        end else if (master == 4'h0) begin
            slot  <= '0;
            cycle <= '0;
        end else if (osc_tick) begin
            cycle <= cycle + 4'd1;
            if (cycle == LAST_CYCLE) begin
                slot <= (slot == LAST_SLOT) ? 4'h0 : slot + 4'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins

    always_comb begin
        logic [3:0] setting;
        setting = 4'h0;
        selected_levels = (cfg.blink_on_flag && cfg.phase_flip_flag) ?
                          phase_one_levels : phase_zero_levels;
        for (int i = 0; i < PORTS; i++) begin
            setting = cfg.shared_level_flag ? global_setting :
                      intensity_regs[i/2][(i%2)*NIBBLE +: NIBBLE];
            next_drive_n[i] = port_direction[i] |
                pin_level(selected_levels[i], setting, master, slot, cycle);
        end
        ninth_level = (cfg.blink_on_flag && cfg.phase_flip_flag) ?
                      cfg.ninth_level_second_bit : cfg.ninth_level_first_bit;
        next_ninth_drive_n = cfg.int_enable |
            pin_level(ninth_level, global_setting, master, slot, cycle);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_drive_n  <= '1;
            ninth_drive_n <= 1'b1;
        end else begin
            port_drive_n  <= next_drive_n;
            ninth_drive_n <= next_ninth_drive_n;
        end
    end

    // Open drain: the driven value is always low
    assign port_out     = '0;
    assign ninth_output = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_inputs_released;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((port_drive_n | ~$past(port_direction[PORTS-1:0])) == '1);
    endproperty
    a_inputs_released: assert property (p_inputs_released)
        else $error("input port driven low");

    property p_blink_off_phase_zero;
        @(posedge clk) disable iff (rst)
        (!cfg.blink_on_flag && master == 4'h0 && port_direction == 8'h00)
        |=> (port_drive_n == $past(phase_zero_levels[PORTS-1:0]));
    endproperty
    a_blink_off_phase_zero: assert property (p_blink_off_phase_zero)
        else $error("blink off did not follow phase-zero levels");

    property p_blink_phase_one;
        @(posedge clk) disable iff (rst)
        (cfg.blink_on_flag && cfg.phase_flip_flag && master == 4'h0 &&
         port_direction == 8'h00)
        |=> (port_drive_n == $past(phase_one_levels[PORTS-1:0]));
    endproperty
    a_blink_phase_one: assert property (p_blink_phase_one)
        else $error("flipped blink did not follow phase-one levels");

    property p_osc_stopped;
        @(posedge clk) disable iff (rst)
        (master == 4'h0) |=> (osc_div == '0 && slot == '0 && cycle == '0);
    endproperty
    a_osc_stopped: assert property (p_osc_stopped)
        else $error("oscillator ran with master zero");

    property p_period_wrap;
        @(posedge clk) disable iff (rst)
        (osc_tick && slot == LAST_SLOT && cycle == LAST_CYCLE && master != 4'h0)
        |=> (slot == 4'h0 && cycle == 4'h0);
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("period did not wrap after last slot");

    property p_tick_spacing;
        @(posedge clk) disable iff (rst)
        (osc_tick && master != 4'h0) |=> (!osc_tick)[*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("oscillator ticks too close together");

    property p_read_phase_one;
        @(posedge clk) disable iff (rst)
        (reg_read && reg_addr == ADDR_PHASE_ONE) |=> (reg_rdata == $past(phase_one_levels));
    endproperty
    a_read_phase_one: assert property (p_read_phase_one)
        else $error("phase-one read back wrong");

    property p_direction_write;
        @(posedge clk) disable iff (rst)
        (reg_write && reg_addr == ADDR_DIRECTION) |=> (port_direction == $past(reg_wdata));
    endproperty
    a_direction_write: assert property (p_direction_write)
        else $error("direction write lost");

    property p_full_static;
        @(posedge clk) disable iff (rst)
        (!cfg.shared_level_flag && intensity_regs[1][7:4] == SETTING_STATIC &&
         !port_direction[3] && !cfg.blink_on_flag)
        |=> (port_drive_n[3] == $past(phase_zero_levels[3]));
    endproperty
    a_full_static: assert property (p_full_static)
        else $error("full setting not static");

    property p_ungated_slot;
        @(posedge clk) disable iff (rst)
        (master != 4'h0 && slot >= master && !cfg.shared_level_flag &&
         intensity_regs[0][3:0] == 4'h0 && !port_direction[0] &&
         !cfg.blink_on_flag && !phase_zero_levels[0])
        |=> port_drive_n[0];
    endproperty
    a_ungated_slot: assert property (p_ungated_slot)
        else $error("output on outside gated slot");

    property p_global_off_time;
        @(posedge clk) disable iff (rst)
        (cfg.shared_level_flag && master != 4'h0 && global_setting == 4'h0 &&
         cycle != 4'h0 && port_direction == 8'h00 && !cfg.blink_on_flag &&
         phase_zero_levels == 8'h00)
        |=> (port_drive_n == '1);
    endproperty
    a_global_off_time: assert property (p_global_off_time)
        else $error("global setting off-time wrong");

    property p_ninth_phase_zero;
        @(posedge clk) disable iff (rst)
        (!cfg.int_enable && cfg.blink_on_flag && !cfg.phase_flip_flag && master == 4'h0)
        |=> (ninth_drive_n == $past(cfg.ninth_level_first_bit));
    endproperty
    a_ninth_phase_zero: assert property (p_ninth_phase_zero)
        else $error("ninth output phase-zero level wrong");

    property p_read_phase_zero;
        @(posedge clk) disable iff (rst)
        (reg_read && reg_addr == ADDR_PHASE_ZERO) |=> (reg_rdata == $past(phase_zero_levels));
    endproperty
    a_read_phase_zero: assert property (p_read_phase_zero)
        else $error("phase-zero read back wrong");

    property p_cycle_hold;
        @(posedge clk) disable iff (rst)
        (!osc_tick && master != 4'h0) |=> (cycle == $past(cycle) && slot == $past(slot));
    endproperty
    a_cycle_hold: assert property (p_cycle_hold)
        else $error("PWM counters moved between ticks");

    property p_slot_advance;
        @(posedge clk) disable iff (rst)
        (osc_tick && cycle == LAST_CYCLE && slot != LAST_SLOT && master != 4'h0)
        |=> (cycle == 4'h0 && slot == $past(slot) + 4'd1);
    endproperty
    a_slot_advance: assert property (p_slot_advance)
        else $error("timeslot did not advance after sixteen cycles");

    property p_gated_on_time;
        @(posedge clk) disable iff (rst)
        (master != 4'h0 && slot < master && !cfg.shared_level_flag &&
         intensity_regs[0][3:0] != SETTING_STATIC && cycle <= intensity_regs[0][3:0] &&
         !port_direction[0] && !cfg.blink_on_flag)
        |=> (port_drive_n[0] == $past(phase_zero_levels[0]));
    endproperty
    a_gated_on_time: assert property (p_gated_on_time)
        else $error("on-time level wrong inside gated slot");

    property p_shared_overrides;
        @(posedge clk) disable iff (rst)
        (cfg.shared_level_flag && !cfg.blink_on_flag && master != 4'h0 &&
         global_setting != SETTING_STATIC && cycle > global_setting)
        |=> (port_drive_n == ($past(port_direction[PORTS-1:0]) |
                              ~$past(phase_zero_levels[PORTS-1:0])));
    endproperty
    a_shared_overrides: assert property (p_shared_overrides)
        else $error("global setting did not govern every port");

    property p_ninth_off_time;
        @(posedge clk) disable iff (rst)
        (!cfg.int_enable && !cfg.blink_on_flag && master != 4'h0 &&
         global_setting != SETTING_STATIC && (slot >= master || cycle > global_setting))
        |=> (ninth_drive_n == !$past(cfg.ninth_level_first_bit));
    endproperty
    a_ninth_off_time: assert property (p_ninth_off_time)
        else $error("ninth output off-time level wrong");

endmodule : port_blink_pwm_output_control

// ### hdl/port_pwm_pkg.sv
package port_pwm_pkg;

    // Register address codes
    localparam logic [7:0] ADDR_INPUT_LEVELS = 8'h00;
    localparam logic [7:0] ADDR_PHASE_ZERO   = 8'h01;
    localparam logic [7:0] ADDR_DIRECTION    = 8'h03;
    localparam logic [7:0] ADDR_PHASE_ONE    = 8'h09;
    localparam logic [7:0] ADDR_MASTER       = 8'h0E;
    localparam logic [7:0] ADDR_CONFIG       = 8'h0F;
    localparam logic [7:0] ADDR_INTENSITY0   = 8'h10;
    localparam logic [7:0] ADDR_INTENSITY3   = 8'h13;

    // Power-up values
    localparam logic [7:0] RESET_LEVELS      = 8'hFF;
    localparam logic [7:0] RESET_DIRECTION   = 8'hFF;
    localparam logic [7:0] RESET_MASTER      = 8'h0F;
    localparam logic [7:0] RESET_CONFIG      = 8'h0C;
    localparam logic [7:0] RESET_INTENSITY   = 8'hFF;
    localparam logic [7:0] READ_UNMAPPED     = 8'h00;

    // Configuration register bit positions
    localparam int CFG_BLINK_BIT  = 0;
    localparam int CFG_FLIP_BIT   = 1;
    localparam int CFG_GLOBAL_BIT = 2;
    localparam int CFG_INT_EN_BIT = 3;
    localparam int CFG_FIRST_BIT  = 4;
    localparam int CFG_SECOND_BIT = 5;

    // Master register fields
    localparam int MASTER_LSB = 4;
    localparam int NIBBLE     = 4;

    // PWM timing
    localparam int CLK_FREQ_HZ  = 40_000_000;
    localparam int OSC_FREQ_HZ  = 32_000;
    localparam int OSC_DIV      = CLK_FREQ_HZ / OSC_FREQ_HZ;
    localparam int SLOT_COUNT   = 15;
    localparam int CYCLE_COUNT  = 16;
    localparam logic [3:0] SETTING_STATIC = 4'hF;
    localparam logic [3:0] LAST_SLOT      = 4'(SLOT_COUNT - 1);
    localparam logic [3:0] LAST_CYCLE     = 4'(CYCLE_COUNT - 1);

    typedef struct packed {
        logic ninth_level_second_bit;
        logic ninth_level_first_bit;
        logic int_enable;
        logic shared_level_flag;
        logic phase_flip_flag;
        logic blink_on_flag;
    } config_type;

endpackage : port_pwm_pkg

// ### verif/led_load_model.sv
`timescale 1ns/100ps

// Open-drain loads with pull-ups; the bench may also pull an input pin low
module led_load_model (
    input  wire logic [7:0] port_out,
    input  wire logic [7:0] port_drive_n,
    input  wire logic       ninth_output,
    input  wire logic       ninth_drive_n,
    input  wire logic [7:0] ext_pull_low,
    output logic      [7:0] pin_level,
    output logic            ninth_level
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = (port_drive_n[i] ? 1'b1 : port_out[i]) & ~ext_pull_low[i];
        end
        ninth_level = ninth_drive_n ? 1'b1 : ninth_output;
    end
endmodule : led_load_model

// ### verif/port_blink_pwm_output_control_bench.sv
`timescale 1ns/100ps

module port_blink_pwm_output_control_bench;
    import port_pwm_pkg::*;
    logic       clk;
    logic       rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_rdata;
    logic [7:0] port_out;
    logic [7:0] port_drive_n;
    logic       ninth_output;
    logic       ninth_drive_n;
    logic [7:0] ext_pull_low;
    logic [7:0] pin_level;
    logic       ninth_level;
    int         n_errors;
    int         samples_checked;
    int         rel [9];
    int         expc [9];

    port_blink_pwm_output_control #(.PORTS(8)) i_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .port_in(pin_level), .port_out(port_out), .port_drive_n(port_drive_n),
        .ninth_output(ninth_output), .ninth_drive_n(ninth_drive_n)
    );

    led_load_model i_load (
        .port_out(port_out), .port_drive_n(port_drive_n), .ninth_output(ninth_output),
        .ninth_drive_n(ninth_drive_n), .ext_pull_low(ext_pull_low),
        .pin_level(pin_level), .ninth_level(ninth_level)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        reg_read = 1'b0;
        check(name, reg_rdata, exp);
        @(negedge clk);
    endtask : rd

    // Unknown pin levels count heavily so that they never slip through
    function automatic int count_level(input logic lvl);
        return (lvl === 1'b1) ? 1 : ((lvl === 1'b0) ? 0 : 100_000);
    endfunction : count_level

    // Counts released cycles per pin, then compares with a small latency allowance
    task automatic window(input int n, input string name);
        rel = '{default: 0};
        repeat (n) begin
            @(negedge clk);
            for (int i = 0; i < 8; i++) rel[i] += count_level(pin_level[i]);
            rel[8] += count_level(ninth_level);
        end
        for (int i = 0; i < 9; i++) begin
            check(name, (rel[i] - expc[i] <= 3 && expc[i] - rel[i] <= 3) ? expc[i] : rel[i],
                  expc[i]);
        end
    endtask : window

    ////////////////////////////////////////////////////////////////////////////////
    task automatic reset_values;
        check("drive after reset", {ninth_drive_n, port_drive_n}, 9'h1FF);
        rd(ADDR_DIRECTION, RESET_DIRECTION, "direction reset");
        rd(ADDR_MASTER, RESET_MASTER, "master reset");
        rd(ADDR_CONFIG, RESET_CONFIG, "config reset");
        rd(ADDR_INTENSITY3, RESET_INTENSITY, "intensity reset");
        rd(8'h05, READ_UNMAPPED, "unmapped read");
    endtask : reset_values

    task automatic stored_vs_pins;
        ext_pull_low = 8'h0F;
        wr(ADDR_PHASE_ZERO, 8'hA5);
        wr(ADDR_PHASE_ONE, 8'h3C);
        wr(ADDR_INPUT_LEVELS, 8'h55);
        repeat (4) @(negedge clk);
        rd(ADDR_INPUT_LEVELS, 8'hF0, "pin levels");
        rd(ADDR_PHASE_ZERO, 8'hA5, "phase zero stored");
        rd(ADDR_PHASE_ONE, 8'h3C, "phase one stored");
        ext_pull_low = 8'h00;
        wr(ADDR_DIRECTION, 8'h96);
        rd(ADDR_DIRECTION, 8'h96, "direction readback");
    endtask : stored_vs_pins

    task automatic static_levels;
        logic [7:0] cfg [4] = '{8'h20, 8'h21, 8'h23, 8'h12};
        logic [7:0] lvl [4] = '{8'h5A, 8'h5A, 8'h0F, 8'h5A};
        logic       nin [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
        wr(ADDR_INTENSITY0, 8'h00);
        wr(ADDR_MASTER, 8'h00);
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_PHASE_ZERO, 8'h5A);
        wr(ADDR_PHASE_ONE, 8'h0F);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CONFIG, cfg[k]);
            repeat (3) @(negedge clk);
            check("port drive", port_drive_n, lvl[k]);
            check("ninth drive", ninth_drive_n, nin[k]);
        end
        wr(ADDR_DIRECTION, 8'hF0);
        rd(ADDR_CONFIG, 8'h12, "config readback");
        for (int i = 0; i < 8; i++) expc[i] = ((8'hFA >> i) & 1) * 3000;
        expc[8] = 3000;
        window(3000, "static pins");
    endtask : static_levels

    task automatic pwm_individual;
        wr(ADDR_CONFIG, 8'h10);
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_PHASE_ZERO, 8'hFE);
        wr(8'h10, 8'h30);
        wr(8'h11, 8'hFE);
        wr(8'h12, 8'hF0);
        wr(8'h13, 8'h77);
        wr(ADDR_MASTER, 8'h10);
        expc = '{20750, 5000, 18750, 22000, 1250, 22000, 10000, 10000, 1250};
        window(22000, "individual duty");
    endtask : pwm_individual

    task automatic pwm_global;
        wr(ADDR_MASTER, 8'h00);
        wr(ADDR_PHASE_ZERO, 8'h00);
        wr(ADDR_CONFIG, 8'h04);
        wr(ADDR_MASTER, 8'h20);
        expc = '{default: 20500};
        window(23000, "global duty");
    endtask : pwm_global

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        wrap_up();
    end

    initial begin
        n_errors        = 0;
        samples_checked = 0;
        rst             = 1'b1;
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        reg_write       = 1'b0;
        reg_read        = 1'b0;
        ext_pull_low    = 8'h00;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        reset_values();
        stored_vs_pins();
        static_levels();
        pwm_individual();
        pwm_global();
        wrap_up();
    end
endmodule : port_blink_pwm_output_control_bench
